// [sim/adcsq_checker.sv]
// Port-level assertions for the conversion sequencer
module adcsq_checker
    import adcsq_pkg::*;
(
    input  wire logic                CLK_I,
    input  wire logic                RSTN_I,
    input  wire logic                CONVERTER_ENABLE_I,
    input  wire logic                AUTO_TRIGGER_ENABLE_I,
    input  wire logic                FREE_RUNNING_I,
    input  wire logic                DONE_FLAG_CLEAR_I,
    input  wire logic                RESULT_LOW_READ_I,
    input  wire logic                RESULT_HIGH_READ_I,
    input  wire logic                ANALOG_OVERRANGE_I,
    input  wire logic                CONVERSION_START_BIT_O,
    input  wire logic                CONVERSION_DONE_FLAG_O,
    input  wire logic [RESULT_W-1:0] RESULT_O,
    input  wire logic                SAMPLE_O,
    input  wire logic [CHAN_W-1:0]   ACTIVE_CHANNEL_O,
    input  wire logic [REF_W-1:0]    ACTIVE_REFERENCE_O,
    input  wire logic [CHAN_W-1:0]   TEMP_CHANNEL_O,
    input  wire logic [REF_W-1:0]    TEMP_REFERENCE_O
);
    timeunit 1ns;
    timeprecision 1ps;
    logic blk_ff;
    logic nxt_blk;
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!RSTN_I);
    // Mirror of the read lock; a high read wins over a low read in one cycle
    always_comb begin
        nxt_blk = blk_ff;
        if (RESULT_LOW_READ_I) nxt_blk = 1'b1;
        if (RESULT_HIGH_READ_I) nxt_blk = 1'b0;
    end
    always_ff @(posedge CLK_I) begin
        if (!RSTN_I) blk_ff <= 1'b0;
        else blk_ff <= nxt_blk;
    end
    a_done_clears_start: assert property ($rose(CONVERSION_DONE_FLAG_O)
        && !(AUTO_TRIGGER_ENABLE_I && FREE_RUNNING_I) |-> !CONVERSION_START_BIT_O)
        else $error("start bit still set at completion");
    a_free_keeps_start: assert property ($rose(CONVERSION_DONE_FLAG_O)
        && AUTO_TRIGGER_ENABLE_I && FREE_RUNNING_I && CONVERTER_ENABLE_I
        |-> CONVERSION_START_BIT_O) else $error("free running start bit dropped");
    a_off_clears_start: assert property (!CONVERTER_ENABLE_I |=>
        !CONVERSION_START_BIT_O) else $error("start bit survives disable");
    a_off_no_sample: assert property (!CONVERTER_ENABLE_I [*3] |-> !SAMPLE_O)
        else $error("sample while disabled");
    a_sample_spacing: assert property (SAMPLE_O |=> !SAMPLE_O [*8])
        else $error("samples too close");
    a_lock_at_sample: assert property (SAMPLE_O |-> $stable(ACTIVE_CHANNEL_O)
        && $stable(ACTIVE_REFERENCE_O)) else $error("selection moved at sample");
    a_idle_follows: assert property ((CONVERTER_ENABLE_I && !CONVERSION_START_BIT_O
        && $stable(TEMP_CHANNEL_O) && $stable(TEMP_REFERENCE_O)) [*2]
        |-> ACTIVE_CHANNEL_O == TEMP_CHANNEL_O && ACTIVE_REFERENCE_O == TEMP_REFERENCE_O)
        else $error("idle selection not copied");
    a_result_hold: assert property (blk_ff && !RESULT_HIGH_READ_I
        |=> $stable(RESULT_O)) else $error("result changed while locked");
    a_flag_sticky: assert property (CONVERSION_DONE_FLAG_O && !DONE_FLAG_CLEAR_I
        |=> CONVERSION_DONE_FLAG_O) else $error("done flag lost");
    a_full_scale: assert property ($rose(CONVERSION_DONE_FLAG_O)
        && $past(ANALOG_OVERRANGE_I) && !$past(blk_ff) && !$past(RESULT_LOW_READ_I)
        |-> RESULT_O == RESULT_FULL) else $error("overrange not full scale");
    c_done: cover property ($rose(CONVERSION_DONE_FLAG_O));
    c_auto: cover property (SAMPLE_O && AUTO_TRIGGER_ENABLE_I && !FREE_RUNNING_I);
    c_lost: cover property (blk_ff && $rose(CONVERSION_DONE_FLAG_O));
endmodule

// [sim/adcsq_far_model.sv]
// Far-side model: on-chip trigger source and converter result
module adcsq_far_model
    import adcsq_pkg::*;
(
    input  wire logic                clk_i,
    input  wire logic                rstn_i,
    input  wire logic                fire_i,
    input  wire logic [5:0]          hold_i,
    input  wire logic                sample_i,
    output logic                     trigger_o,
    output logic [RESULT_W-1:0]      analog_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [5:0]          left_ff;
    logic [RESULT_W-1:0] smp_ff;
    // Trigger stays high hold_i cycles, then drops so a later fire is a fresh edge
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            left_ff <= 6'h00;
            smp_ff <= 10'h000;
        end else begin
            if (fire_i) left_ff <= hold_i;
            else if (left_ff != 6'h00) left_ff <= left_ff - 6'h01;
            if (sample_i) smp_ff <= smp_ff + 10'h001;
        end
    end
    assign trigger_o = (left_ff != 6'h00);
    // Code moves with every sample so a stale result never passes
    assign analog_o = 10'h100 + smp_ff;
endmodule

// [sim/tb_top.sv]
// Self-checking bench for the conversion sequencer
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import adcsq_pkg::*;
    logic CLK_I, RSTN_I, CONVERTER_ENABLE_I, START_WRITE_I, AUTO_TRIGGER_ENABLE_I;
    logic FREE_RUNNING_I, TRIGGER_I, DIFFERENTIAL_I, SELECT_WRITE_I, DONE_FLAG_CLEAR_I;
    logic RESULT_LOW_READ_I, RESULT_HIGH_READ_I, ANALOG_OVERRANGE_I, SAMPLE_O;
    logic CONVERSION_START_BIT_O, CONVERSION_DONE_FLAG_O, fire, done_q;
    logic [DIVSEL_W-1:0] CLOCK_DIVIDER_SELECT_I;
    logic [CHAN_W-1:0] CHANNEL_SELECT_I, ACTIVE_CHANNEL_O, TEMP_CHANNEL_O, ch_seen;
    logic [REF_W-1:0] REFERENCE_SELECT_I, ACTIVE_REFERENCE_O, TEMP_REFERENCE_O;
    logic [RESULT_W-1:0] ANALOG_RESULT_I, RESULT_O, keep;
    logic [5:0] hold;
    int cyc = 0, n_smp = 0, t_smp = 0, gap = 0, t_done = 0, t0, t_trg;
    int bad_count = 0, n_compared = 0;
    adcsq_top uut (.*);
    adcsq_far_model far (.clk_i(CLK_I), .rstn_i(RSTN_I), .fire_i(fire), .hold_i(hold),
        .sample_i(SAMPLE_O), .trigger_o(TRIGGER_I), .analog_o(ANALOG_RESULT_I));
    initial begin
        CLK_I = 1'b0;
        forever #4 CLK_I = ~CLK_I;
    end
    // Log samples and completions just after each edge; cut a hang short
    always @(posedge CLK_I) begin
        cyc++;
        #1;
        if (SAMPLE_O === 1'b1) begin
            gap = cyc - t_smp;
            t_smp = cyc;
            ch_seen = ACTIVE_CHANNEL_O;
            n_smp++;
        end
        if (CONVERSION_DONE_FLAG_O === 1'b1 && done_q !== 1'b1) t_done = cyc;
        done_q = CONVERSION_DONE_FLAG_O;
        if (cyc == 9000) begin
            bad_count++;
            complete_run();
        end
    end
    task automatic complete_run();
        $display("Compared %0d, mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(negedge CLK_I);
    endtask
    // Reference rides on the channel low bits; results after a change are checked
    // only as sequence codes, never for accuracy
    task automatic sel_wr(input logic [CHAN_W-1:0] ch);
        CHANNEL_SELECT_I = ch;
        REFERENCE_SELECT_I = ch[1:0];
        SELECT_WRITE_I = 1'b1;
        step(1);
        SELECT_WRITE_I = 1'b0;
    endtask
    task automatic strobe_start();
        START_WRITE_I = 1'b1;
        step(1);
        START_WRITE_I = 1'b0;
    endtask
    task automatic clear_done();
        DONE_FLAG_CLEAR_I = 1'b1;
        step(1);
        DONE_FLAG_CLEAR_I = 1'b0;
    endtask
    task automatic fire_trig();
        t_trg = cyc;
        fire = 1'b1;
        step(1);
        fire = 1'b0;
    endtask
    task automatic wait_done();
        for (int i = 0; i < 400 && CONVERSION_DONE_FLAG_O !== 1'b1; i++) step(1);
    endtask
    task automatic wait_smp(input int k);
        int goal;
        goal = n_smp + k;
        for (int i = 0; i < 400 && n_smp < goal; i++) step(1);
        check(16'(n_smp >= goal), 16'h1);
    endtask
    // Software start with a selection write while the conversion runs
    task automatic single(input int lo, input int hi, input logic [CHAN_W-1:0] nxt);
        logic [CHAN_W-1:0] was;
        was = ACTIVE_CHANNEL_O;
        clear_done();
        t0 = cyc;
        strobe_start();
        step(12);
        sel_wr(nxt);
        wait_done();
        check(16'(t_done - t0 >= lo && t_done - t0 <= hi), 16'h1);
        check(16'(t_done - t_smp), 16'd23);
        check(16'(CONVERSION_START_BIT_O), 16'h0);
        check(16'(ch_seen), 16'(was));
        check(16'(ACTIVE_CHANNEL_O), 16'(nxt));
    endtask
    initial begin
        {CONVERTER_ENABLE_I, START_WRITE_I, AUTO_TRIGGER_ENABLE_I, FREE_RUNNING_I} = 4'h0;
        {DIFFERENTIAL_I, SELECT_WRITE_I, DONE_FLAG_CLEAR_I, ANALOG_OVERRANGE_I} = 4'h0;
        {RESULT_LOW_READ_I, RESULT_HIGH_READ_I, fire, RSTN_I} = 4'h0;
        CLOCK_DIVIDER_SELECT_I = 3'h0;
        CHANNEL_SELECT_I = 6'h00;
        REFERENCE_SELECT_I = 2'h0;
        hold = 6'h04;
        step(16);
        RSTN_I = 1'b1;
        sel_wr(6'h05);
        step(2);
        check(16'(TEMP_CHANNEL_O), 16'h5);
        check(16'(ACTIVE_REFERENCE_O), 16'h1);
        check(16'(TEMP_REFERENCE_O), 16'h1);
        CONVERTER_ENABLE_I = 1'b1;
        single(51, 57, 6'h09);
        single(27, 33, 6'h0a);
        check(16'(RESULT_O), 16'(10'h100 + n_smp));
        ANALOG_OVERRANGE_I = 1'b1;
        single(27, 33, 6'h0b);
        check(16'(RESULT_O), 16'(RESULT_FULL));
        ANALOG_OVERRANGE_I = 1'b0;
        // Low-byte read freezes the result until the high byte goes
        keep = RESULT_O;
        RESULT_LOW_READ_I = 1'b1;
        step(1);
        RESULT_LOW_READ_I = 1'b0;
        single(27, 33, 6'h0c);
        check(16'(RESULT_O), 16'(keep));
        check(16'(CONVERSION_DONE_FLAG_O), 16'h1);
        RESULT_HIGH_READ_I = 1'b1;
        step(1);
        RESULT_HIGH_READ_I = 1'b0;
        single(27, 33, 6'h0d);
        check(16'(RESULT_O), 16'(10'h100 + n_smp));
        // Differential user start lasts 13 or 14 cycles by half-rate phase
        DIFFERENTIAL_I = 1'b1;
        single(27, 33, 6'h0d);
        DIFFERENTIAL_I = 1'b0;
        // Triggered conversion; a second edge mid-way and a held level are ignored
        AUTO_TRIGGER_ENABLE_I = 1'b1;
        clear_done();
        t0 = n_smp;
        fire_trig();
        step(12);
        // Second edge keeps the first trigger time for the sample check
        fire = 1'b1;
        step(1);
        fire = 1'b0;
        wait_done();
        check(16'(t_smp - t_trg >= 7 && t_smp - t_trg <= 11), 16'h1);
        check(16'(t_done - t_smp), 16'd23);
        hold = 6'h30;
        step(30);
        fire_trig();
        step(100);
        check(16'(n_smp - t0), 16'h2);
        // Free running: back-to-back restarts, a selection change lags by one
        FREE_RUNNING_I = 1'b1;
        strobe_start();
        wait_smp(3);
        check(16'(gap), 16'd26);
        check(16'(CONVERSION_START_BIT_O), 16'h1);
        clear_done();
        wait_done();
        sel_wr(6'h21);
        wait_smp(1);
        check(16'(ch_seen), 16'h0d);
        wait_smp(1);
        check(16'(ch_seen), 16'h21);
        DIFFERENTIAL_I = 1'b1;
        wait_smp(3);
        check(16'(gap), 16'd28);
        CONVERTER_ENABLE_I = 1'b0; // Off then on between the differential and divide-by-four runs
        step(3);
        check(16'(CONVERSION_START_BIT_O), 16'h0);
        t0 = n_smp;
        step(60);
        check(16'(n_smp - t0), 16'h0);
        // Divide-by-four converter clock doubles every spacing
        DIFFERENTIAL_I = 1'b0;
        CLOCK_DIVIDER_SELECT_I = 3'h1;
        CONVERTER_ENABLE_I = 1'b1;
        step(1);
        strobe_start();
        wait_smp(3);
        check(16'(gap), 16'd52);
        complete_run();
    end
endmodule
bind adcsq_top adcsq_checker chk (.*);

// [src/adcsq_pkg.sv]
// Constants shared by the conversion sequencer and its clock prescaler
package adcsq_pkg;
    // Sequencer states, one-hot
    typedef enum logic [2:0] {
        SQ_IDLE = 3'b001,
        SQ_WAIT = 3'b010,
        SQ_CONV = 3'b100
    } adcsq_state_e;

    // Field widths
    localparam int RESULT_W  = 10;
    localparam int CHAN_W    = 6;
    localparam int REF_W     = 2;
    localparam int DIVSEL_W  = 3;
    localparam int PRESC_W   = 8;
    localparam int HALF_W    = 6;

    // Reset values and the overrange full-scale code
    localparam logic [RESULT_W-1:0] RESULT_RST    = 10'h000;
    localparam logic [RESULT_W-1:0] RESULT_FULL   = 10'h3ff;
    localparam logic [CHAN_W-1:0]   CHAN_RST      = 6'h00;
    localparam logic [REF_W-1:0]    REF_RST       = 2'h0;

    // Conversion timing, counted in half converter clock cycles
    localparam logic [HALF_W-1:0] NORMAL_END_H   = 6'h1a; // 13 cycles
    localparam logic [HALF_W-1:0] NORMAL_SMP_H   = 6'h03; // 1.5 cycles
    localparam logic [HALF_W-1:0] FIRST_END_H    = 6'h32; // 25 cycles
    localparam logic [HALF_W-1:0] FIRST_SMP_H    = 6'h1b; // 13.5 cycles
    localparam logic [HALF_W-1:0] AUTO_END_H     = 6'h1b; // 13.5 cycles
    localparam logic [HALF_W-1:0] AUTO_SMP_H     = 6'h04; // 2 cycles
    localparam logic [HALF_W-1:0] DIFF_EXT_H     = 6'h02; // 1 extra cycle
    localparam logic [HALF_W-1:0] RELOCK_LEAD_H  = 6'h02; // last cycle

    // Trigger synchroniser depth in CPU clocks
    localparam int TRIG_SYNC_STAGES = 3;
endpackage

// [src/adcsq_prescaler.sv]
// Converter clock prescaler: divides the CPU clock, emits edge strobes
module adcsq_prescaler
    import adcsq_pkg::*;
(
    input  wire logic                clk_i,
    input  wire logic                rstn_i,
    input  wire logic                hold_i,
    input  wire logic [DIVSEL_W-1:0] sel_i,
    output logic                     rise_o,
    output logic                     fall_o,
    output logic                     half_rate_o
);
    logic [PRESC_W-1:0] cnt_ff;
    logic [PRESC_W-1:0] nxt_cnt;
    logic               half_ff;
    logic               nxt_half;
    logic [PRESC_W-1:0] last_cnt;
    logic [PRESC_W-1:0] mid_cnt;

    // Ratio is two to the power (select + 1), from 2 up to 256
    assign last_cnt = PRESC_W'((9'h002 << sel_i) - 9'h001);
    assign mid_cnt  = PRESC_W'((9'h001 << sel_i) - 9'h001);
    assign rise_o   = ~hold_i && (cnt_ff == last_cnt);
    assign fall_o   = ~hold_i && (cnt_ff == mid_cnt);
    assign half_rate_o = half_ff;

    // Counter held at zero while held, else wraps at the ratio
    always_comb begin
        nxt_cnt  = cnt_ff + 8'h01;
        nxt_half = half_ff;
        if (hold_i) begin
            nxt_cnt  = 8'h00;
            nxt_half = 1'b0;
        end else if (cnt_ff >= last_cnt) begin
            nxt_cnt  = 8'h00;
            nxt_half = ~half_ff;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            cnt_ff  <= 8'h00;
            half_ff <= 1'b0;
        end else begin
            cnt_ff  <= nxt_cnt;
            half_ff <= nxt_half;
        end
    end
endmodule

// [src/adcsq_top.sv]
// Conversion sequencer around a 10-bit successive-approximation converter
module adcsq_top
    import adcsq_pkg::*;
(
    input  wire logic                CLK_I,
    input  wire logic                RSTN_I,
    input  wire logic                CONVERTER_ENABLE_I,
    input  wire logic                START_WRITE_I,
    input  wire logic                AUTO_TRIGGER_ENABLE_I,
    input  wire logic                FREE_RUNNING_I,
    input  wire logic [DIVSEL_W-1:0] CLOCK_DIVIDER_SELECT_I,
    input  wire logic                TRIGGER_I,
    input  wire logic                DIFFERENTIAL_I,
    input  wire logic                SELECT_WRITE_I,
    input  wire logic [CHAN_W-1:0]   CHANNEL_SELECT_I,
    input  wire logic [REF_W-1:0]    REFERENCE_SELECT_I,
    input  wire logic                DONE_FLAG_CLEAR_I,
    input  wire logic                RESULT_LOW_READ_I,
    input  wire logic                RESULT_HIGH_READ_I,
    input  wire logic [RESULT_W-1:0] ANALOG_RESULT_I,
    input  wire logic                ANALOG_OVERRANGE_I,
    output logic                     CONVERSION_START_BIT_O,
    output logic                     CONVERSION_DONE_FLAG_O,
    output logic [RESULT_W-1:0]      RESULT_O,
    output logic                     SAMPLE_O,
    output logic [CHAN_W-1:0]        ACTIVE_CHANNEL_O,
    output logic [REF_W-1:0]         ACTIVE_REFERENCE_O,
    output logic [CHAN_W-1:0]        TEMP_CHANNEL_O,
    output logic [REF_W-1:0]         TEMP_REFERENCE_O
);
    adcsq_state_e          state_ff;
    adcsq_state_e          nxt_state;
    logic [HALF_W-1:0]     half_ff;
    logic [HALF_W-1:0]     nxt_half;
    logic                  first_ff;
    logic                  nxt_first;
    logic                  auto_ff;
    logic                  nxt_auto;
    logic                  ext_ff;
    logic                  nxt_ext;
    logic                  start_ff;
    logic                  nxt_start;
    logic                  done_ff;
    logic                  nxt_done;
    logic                  block_ff;
    logic                  nxt_block;
    logic                  lock_ff;
    logic                  nxt_lock;
    logic                  sample_ff;
    logic                  nxt_sample;
    logic [RESULT_W-1:0]   result_ff;
    logic [RESULT_W-1:0]   nxt_result;
    logic [CHAN_W-1:0]     tmp_ch_ff;
    logic [CHAN_W-1:0]     nxt_tmp_ch;
    logic [REF_W-1:0]      tmp_ref_ff;
    logic [REF_W-1:0]      nxt_tmp_ref;
    logic [CHAN_W-1:0]     act_ch_ff;
    logic [CHAN_W-1:0]     nxt_act_ch;
    logic [REF_W-1:0]      act_ref_ff;
    logic [REF_W-1:0]      nxt_act_ref;
    logic [TRIG_SYNC_STAGES-1:0] trig_sync_ff;
    logic                  psc_rise;
    logic                  psc_fall;
    logic                  half_rate;
    logic                  trig_edge;
    logic                  psc_hold;
    logic [HALF_W-1:0]     end_h;
    logic [HALF_W-1:0]     smp_h;
    logic [HALF_W-1:0]     half_inc;
    logic                  complete;

    adcsq_prescaler u_prescaler (
        .clk_i       (CLK_I),
        .rstn_i      (RSTN_I),
        .hold_i      (psc_hold),
        .sel_i       (CLOCK_DIVIDER_SELECT_I),
        .rise_o      (psc_rise),
        .fall_o      (psc_fall),
        .half_rate_o (half_rate)
    );

    // Trigger passes two CPU clocks of synchronisation before the edge
    // detector sees it; stage 0 feeds only stage 1
    always_ff @(posedge CLK_I) begin
        if (!RSTN_I) begin
            trig_sync_ff <= '0;
        end else begin
            trig_sync_ff <= {trig_sync_ff[TRIG_SYNC_STAGES-2:0], TRIGGER_I};
        end
    end

    // Rising trigger edge counts only when idle, so edges during a
    // conversion and a level still high at completion start nothing
    assign trig_edge = trig_sync_ff[TRIG_SYNC_STAGES-2] & ~trig_sync_ff[TRIG_SYNC_STAGES-1]
                     & AUTO_TRIGGER_ENABLE_I & CONVERTER_ENABLE_I
                     & (state_ff == SQ_IDLE);

    // Prescaler is held while disabled and restarted on a trigger
    assign psc_hold = ~CONVERTER_ENABLE_I | trig_edge;

    // Length and sample point of the running conversion; first conversion
    // after enable wins over the triggered length so that the extended
    // conversion after an enable toggle is the valid one
    always_comb begin
        if (first_ff) begin
            end_h = FIRST_END_H;
            smp_h = FIRST_SMP_H;
        end else if (auto_ff) begin
            end_h = AUTO_END_H;
            smp_h = AUTO_SMP_H;
        end else begin
            end_h = NORMAL_END_H;
            smp_h = NORMAL_SMP_H;
        end
        if (ext_ff) begin
            end_h = end_h + DIFF_EXT_H;
            smp_h = smp_h + DIFF_EXT_H;
        end
    end

    assign half_inc = half_ff + 6'h01;
    assign complete = (state_ff == SQ_CONV) && (psc_rise || psc_fall) && (half_inc == end_h);

    // Conversion sequencing
    always_comb begin
        nxt_state  = state_ff;
        nxt_half   = half_ff;
        nxt_first  = first_ff;
        nxt_auto   = auto_ff;
        nxt_ext    = ext_ff;
        nxt_start  = start_ff | START_WRITE_I;
        nxt_lock   = lock_ff;
        nxt_sample = 1'b0;
        case (state_ff)
            SQ_IDLE: begin
                if (trig_edge) begin
                    nxt_state = SQ_CONV;
                    nxt_half  = 6'h00;
                    nxt_auto  = 1'b1;
                    nxt_ext   = 1'b0;
                    nxt_lock  = 1'b1;
                    nxt_start = 1'b1;
                end else if (start_ff) begin
                    nxt_state = SQ_WAIT;
                end
            end
            SQ_WAIT: begin
                if (psc_rise) begin
                    nxt_state = SQ_CONV;
                    nxt_half  = 6'h00;
                    nxt_auto  = 1'b0;
                    nxt_ext   = DIFFERENTIAL_I & half_rate;
                    nxt_lock  = 1'b1;
                end
            end
            SQ_CONV: begin
                if (psc_rise || psc_fall) begin
                    nxt_half = half_inc;
                    if (half_inc == smp_h) begin
                        nxt_sample = 1'b1;
                    end
                    if (half_inc + RELOCK_LEAD_H >= end_h) begin
                        nxt_lock = 1'b0;
                    end
                    if (complete) begin
                        nxt_first = 1'b0;
                        if (FREE_RUNNING_I && AUTO_TRIGGER_ENABLE_I) begin
                            // Restart latches the selection copied in the
                            // last cycle, so a later write waits one more
                            nxt_half = 6'h00;
                            nxt_auto = 1'b0;
                            nxt_ext  = DIFFERENTIAL_I & half_rate;
                            nxt_lock = 1'b1;
                        end else begin
                            nxt_state = SQ_IDLE;
                            nxt_start = 1'b0;
                        end
                    end
                end
            end
            default: begin
                nxt_state = SQ_IDLE;
            end
        endcase
        if (!CONVERTER_ENABLE_I) begin
            nxt_state = SQ_IDLE;
            nxt_first = 1'b1;
            nxt_start = 1'b0;
            nxt_lock  = 1'b0;
            nxt_half  = 6'h00;
        end
    end

    always_ff @(posedge CLK_I) begin
        if (!RSTN_I) begin
            state_ff  <= SQ_IDLE;
            half_ff   <= 6'h00;
            first_ff  <= 1'b1;
            auto_ff   <= 1'b0;
            ext_ff    <= 1'b0;
            start_ff  <= 1'b0;
            lock_ff   <= 1'b0;
            sample_ff <= 1'b0;
        end else begin
            state_ff  <= nxt_state;
            half_ff   <= nxt_half;
            first_ff  <= nxt_first;
            auto_ff   <= nxt_auto;
            ext_ff    <= nxt_ext;
            start_ff  <= nxt_start;
            lock_ff   <= nxt_lock;
            sample_ff <= nxt_sample;
        end
    end

    // Result, done flag and read blocking; a completion in the clear cycle
    // keeps the flag set
    always_comb begin
        nxt_done   = (done_ff & ~DONE_FLAG_CLEAR_I) | complete;
        nxt_block  = (block_ff | RESULT_LOW_READ_I) & ~RESULT_HIGH_READ_I;
        nxt_result = result_ff;
        if (complete && !block_ff) begin
            nxt_result = ANALOG_OVERRANGE_I ? RESULT_FULL : ANALOG_RESULT_I;
        end
    end

    always_ff @(posedge CLK_I) begin
        if (!RSTN_I) begin
            done_ff   <= 1'b0;
            block_ff  <= 1'b0;
            result_ff <= RESULT_RST;
        end else begin
            done_ff   <= nxt_done;
            block_ff  <= nxt_block;
            result_ff <= nxt_result;
        end
    end

    // Temporary selection is written by software; the active copy follows
    // it except while locked, keeping the sampled channel stable
    always_comb begin
        nxt_tmp_ch  = SELECT_WRITE_I ? CHANNEL_SELECT_I : tmp_ch_ff;
        nxt_tmp_ref = SELECT_WRITE_I ? REFERENCE_SELECT_I : tmp_ref_ff;
        nxt_act_ch  = act_ch_ff;
        nxt_act_ref = act_ref_ff;
        if (!lock_ff) begin
            nxt_act_ch  = tmp_ch_ff;
            nxt_act_ref = tmp_ref_ff;
        end
    end

    always_ff @(posedge CLK_I) begin
        if (!RSTN_I) begin
            tmp_ch_ff  <= CHAN_RST;
            tmp_ref_ff <= REF_RST;
            act_ch_ff  <= CHAN_RST;
            act_ref_ff <= REF_RST;
        end else begin
            tmp_ch_ff  <= nxt_tmp_ch;
            tmp_ref_ff <= nxt_tmp_ref;
            act_ch_ff  <= nxt_act_ch;
            act_ref_ff <= nxt_act_ref;
        end
    end

    // Outputs are all taken straight from registers
    assign CONVERSION_START_BIT_O = start_ff;
    assign CONVERSION_DONE_FLAG_O = done_ff;
    assign RESULT_O               = result_ff;
    assign SAMPLE_O               = sample_ff;
    assign ACTIVE_CHANNEL_O       = act_ch_ff;
    assign ACTIVE_REFERENCE_O     = act_ref_ff;
    assign TEMP_CHANNEL_O         = tmp_ch_ff;
    assign TEMP_REFERENCE_O       = tmp_ref_ff;
endmodule
